// ### design/rcr_defs.vh
// Constants for the redriver channel control register bank.
// Assumes inclusion by bare name from the design files only.
`ifndef RCR_DEFS_VH
`define RCR_DEFS_VH

// ************************************************************
// Register offsets on the serial management bus
// ************************************************************
`define RCR_OFS_EQ 8'h04
`define RCR_OFS_SD 8'h05
`define RCR_OFS_DRV 8'h06
`define RCR_OFS_SPARE 8'h07
`define RCR_OFS_BIAS 8'h0f

// ************************************************************
// Reset values
// ************************************************************
`define RCR_RST_EQ 8'h90
`define RCR_RST_SD 8'h04
`define RCR_RST_DRV 8'hc0
`define RCR_RST_SPARE 8'h00
`define RCR_RST_BIAS 8'h00
`define RCR_RD_UNMAPPED 8'h00
// Synchroniser levels {detect, data, clock}: no signal, bus idle
`define RCR_SYNC_RST 3'h3

// ************************************************************
// Equaliser control fields
// ************************************************************
`define RCR_EQ_SDPD 6
`define RCR_EQ_GAIN 5
`define RCR_EQ_PD 3
`define RCR_EQ_BIAS_MSB 1
`define RCR_EQ_BYPASS 0

// ************************************************************
// Signal-detect configuration fields
// ************************************************************
`define RCR_SD_FORCE1 7
`define RCR_SD_FORCE0 6
`define RCR_SD_ATH_HI 5
`define RCR_SD_ATH_LO 4
`define RCR_SD_DTH_HI 3
`define RCR_SD_DTH_LO 2

// ************************************************************
// Driver control fields
// ************************************************************
`define RCR_DRV_SWING_HI 7
`define RCR_DRV_SWING_LO 6
`define RCR_DRIVER_POWERDOWN_OV 5
`define RCR_DRV_MUTE_OV 4
`define RCR_DRIVER_POWERDOWN 3
`define RCR_DRV_CM 2
`define RCR_DRV_MUTE 1
`define RCR_DRV_SRC 0

// ************************************************************
// Bias extension fields in the second register
// ************************************************************
`define RCR_BIAS_HI 5
`define RCR_BIAS_LO 4

`endif

// ### design/rcr_sync.v
// Two-flop synchroniser bank for inputs from outside the clock domain.
// Assumes each input bit is an independent level; no bus coherence.
`timescale 1ns/1ns
`default_nettype none

module rcr_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
	input wire clk,
	input wire reset_n,
	input wire clk_en,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	// ************************************************************
	// Per-bit flop pair
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta;
			reg stable;
			// First flop feeds only the second one
			always @(posedge clk) begin
				if (!reset_n) begin
					meta <= RESET_VAL[i];
					stable <= RESET_VAL[i];
				end else if (clk_en) begin
					meta <= async_in[i];
					stable <= meta;
				end
			end
			assign sync_out[i] = stable;
		end
	endgenerate

endmodule // rcr_sync

`default_nettype wire

// ### design/rcr_channel_regs.v
// Redriver channel control register bank with serial management slave.
// Assumes scl, sda and the analog detect level arrive asynchronously;
// sda is open drain and resolved outside from sda_oe.
//
// Behaviour
// - Equaliser bit 6 powers down signal detect
// - Equaliser bit 5 selects high gain
// - Equaliser bit 0 bypasses first boost stage
// - Bias is bit 1 plus second register bits 5:4
// - Config bit 7 forces detect result one
// - Config bit 6 forces detect result zero
// - Assert threshold 5:4, de-assert threshold 3:2
// - Driver bits 7:6 set output swing
// - Override bit 5 gives manual power-down control
// - Without override, loss of signal powers down
// - Mute override bit 4 selects manual mute
// - Without mute override, detect result controls mute
// - Manual mute acts only under override
// - Driver bit 3 powers down the driver
// - Driver bit 2 disables common-mode loop
// - Driver bit 0 selects crosspoint source
`timescale 1ns/1ns
`default_nettype none
`include "rcr_defs.vh"

module rcr_channel_regs #(
	parameter [6:0] DEV_ADDR = 7'h18
) (
	input wire clk,
	input wire reset_n,
	input wire clk_en,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire sigdet_raw,
	output reg sigdet_result,
	output reg loss_of_signal,
	output reg sigdet_powerdown,
	output reg gain_select_high,
	output reg first_boost_bypass,
	output reg [2:0] equaliser_bias_sel,
	output reg [1:0] sigdet_assert_threshold,
	output reg [1:0] sigdet_deassert_threshold,
	output reg [1:0] output_swing_sel,
	output reg equaliser_powered_down,
	output reg driver_powered_down,
	output reg driver_muted,
	output reg cm_loop_disable,
	output reg crosspoint_source_sel
);

	// ************************************************************
	// Slave states
	// ************************************************************
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_ADDR = 4'h1;
	localparam [3:0] ST_ADDR_ACK = 4'h2;
	localparam [3:0] ST_REG = 4'h3;
	localparam [3:0] ST_REG_ACK = 4'h4;
	localparam [3:0] ST_WDATA = 4'h5;
	localparam [3:0] ST_WDATA_ACK = 4'h6;
	localparam [3:0] ST_RDATA = 4'h7;
	localparam [3:0] ST_RACK = 4'h8;
	localparam [2:0] LAST_BIT = 3'h7;

	// ************************************************************
	// Declarations
	// ************************************************************
	wire [2:0] synced;
	wire scl_s;
	wire sda_s;
	wire sigdet_s;
	reg scl_d;
	reg sda_d;
	wire scl_rise;
	wire scl_fall;
	wire start_cond;
	wire stop_cond;
	reg [3:0] state;
	reg [2:0] bit_cnt;
	reg byte_full;
	reg [7:0] shift_in;
	reg [7:0] shift_out;
	reg rd_dir;
	reg [7:0] pointer;
	reg wr_en;
	reg [7:0] rd_data;
	reg [7:0] eq_ctrl;
	reg [7:0] sd_cfg;
	reg [7:0] drv_ctrl;
	reg [7:0] spare_ctrl;
	reg [7:0] bias_ext;
	reg next_sigdet;
	reg next_los;

	// ************************************************************
	// Pin sampling
	// ************************************************************
	// Detect resets to no signal, else reset briefly unmutes the driver
	rcr_sync #(
		.WIDTH(3),
		.RESET_VAL(`RCR_SYNC_RST)
	) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.async_in({sigdet_raw, sda_in, scl_in}),
		.sync_out(synced)
	);

	assign scl_s = synced[0];
	assign sda_s = synced[1];
	assign sigdet_s = synced[2];

	// Delayed copies for edge detection
	always @(posedge clk) begin
		if (!reset_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else if (clk_en) begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// Bus events; start and stop only while scl is high
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

	// ************************************************************
	// Serial management slave
	// ************************************************************
	// Data changes on scl fall, is sampled on scl rise.
	// Pointer auto-increments so a burst walks the map.
	always @(posedge clk) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			bit_cnt <= 3'h0;
			byte_full <= 1'b0;
			shift_in <= 8'h00;
			shift_out <= 8'h00;
			rd_dir <= 1'b0;
			pointer <= 8'h00;
			wr_en <= 1'b0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end else if (clk_en) begin
			wr_en <= 1'b0;
			if (start_cond) begin
				state <= ST_ADDR;
				bit_cnt <= 3'h0;
				byte_full <= 1'b0;
				sda_oe <= 1'b0;
			end else if (stop_cond) begin
				state <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					ST_ADDR, ST_REG, ST_WDATA: begin
						shift_in <= {shift_in[6:0], sda_s};
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == LAST_BIT) begin
							byte_full <= 1'b1;
						end
					end
					ST_RDATA: begin
						bit_cnt <= bit_cnt + 3'h1;
					end
					ST_RACK: begin
						// Master nack ends the burst
						if (sda_s) begin
							state <= ST_IDLE;
						end else begin
							pointer <= pointer + 8'h01;
						end
					end
					default: begin
						bit_cnt <= bit_cnt;
					end
				endcase
			end else if (scl_fall) begin
				case (state)
					ST_ADDR: begin
						if (byte_full) begin
							byte_full <= 1'b0;
							if (shift_in[7:1] == DEV_ADDR) begin
								rd_dir <= shift_in[0];
								sda_oe <= 1'b1;
								state <= ST_ADDR_ACK;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					ST_ADDR_ACK: begin
						bit_cnt <= 3'h0;
						if (rd_dir) begin
							shift_out <= {rd_data[6:0], 1'b0};
							sda_oe <= ~rd_data[7];
							state <= ST_RDATA;
						end else begin
							sda_oe <= 1'b0;
							state <= ST_REG;
						end
					end
					ST_REG: begin
						if (byte_full) begin
							byte_full <= 1'b0;
							pointer <= shift_in;
							sda_oe <= 1'b1;
							state <= ST_REG_ACK;
						end
					end
					ST_REG_ACK: begin
						sda_oe <= 1'b0;
						bit_cnt <= 3'h0;
						state <= ST_WDATA;
					end
					ST_WDATA: begin
						if (byte_full) begin
							byte_full <= 1'b0;
							wr_en <= 1'b1;
							sda_oe <= 1'b1;
							state <= ST_WDATA_ACK;
						end
					end
					ST_WDATA_ACK: begin
						sda_oe <= 1'b0;
						bit_cnt <= 3'h0;
						pointer <= pointer + 8'h01;
						state <= ST_WDATA;
					end
					ST_RDATA: begin
						// Eight bits out, release for master ack
						if (bit_cnt == 3'h0) begin
							sda_oe <= 1'b0;
							state <= ST_RACK;
						end else begin
							sda_oe <= ~shift_out[7];
							shift_out <= {shift_out[6:0], 1'b0};
						end
					end
					ST_RACK: begin
						shift_out <= {rd_data[6:0], 1'b0};
						sda_oe <= ~rd_data[7];
						bit_cnt <= 3'h0;
						state <= ST_RDATA;
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// Register storage
	// ************************************************************
	// Every bit is stored, reserved ones included
	always @(posedge clk) begin
		if (!reset_n) begin
			eq_ctrl <= `RCR_RST_EQ;
			sd_cfg <= `RCR_RST_SD;
			drv_ctrl <= `RCR_RST_DRV;
			spare_ctrl <= `RCR_RST_SPARE;
			bias_ext <= `RCR_RST_BIAS;
		end else if (clk_en && wr_en) begin
			case (pointer)
				`RCR_OFS_EQ: eq_ctrl <= shift_in;
				`RCR_OFS_SD: sd_cfg <= shift_in;
				`RCR_OFS_DRV: drv_ctrl <= shift_in;
				`RCR_OFS_SPARE: spare_ctrl <= shift_in;
				`RCR_OFS_BIAS: bias_ext <= shift_in;
				default: spare_ctrl <= spare_ctrl;
			endcase
		end
	end

	// Read mux; unmapped offsets read as zero
	always @* begin
		case (pointer)
			`RCR_OFS_EQ: rd_data = eq_ctrl;
			`RCR_OFS_SD: rd_data = sd_cfg;
			`RCR_OFS_DRV: rd_data = drv_ctrl;
			`RCR_OFS_SPARE: rd_data = spare_ctrl;
			`RCR_OFS_BIAS: rd_data = bias_ext;
			default: rd_data = `RCR_RD_UNMAPPED;
		endcase
	end

	// ************************************************************
	// Signal-detect result
	// ************************************************************
	// Force-one wins if software breaks the one-force limit;
	// a powered-down detector reports no signal unless force-one is set.
	always @* begin
		if (sd_cfg[`RCR_SD_FORCE1]) begin
			next_sigdet = 1'b1;
		end else if (sd_cfg[`RCR_SD_FORCE0]) begin
			next_sigdet = 1'b0;
		end else if (eq_ctrl[`RCR_EQ_SDPD]) begin
			next_sigdet = 1'b0;
		end else begin
			next_sigdet = sigdet_s;
		end
		next_los = ~next_sigdet;
	end

	// ************************************************************
	// Analog control outputs
	// ************************************************************
	// All registered so the analog side sees clean levels
	always @(posedge clk) begin
		if (!reset_n) begin
			sigdet_result <= 1'b0;
			loss_of_signal <= 1'b1;
			sigdet_powerdown <= 1'b0;
			gain_select_high <= 1'b0;
			first_boost_bypass <= 1'b0;
			equaliser_bias_sel <= 3'h0;
			sigdet_assert_threshold <= 2'h0;
			sigdet_deassert_threshold <= 2'h1;
			output_swing_sel <= 2'h3;
			equaliser_powered_down <= 1'b1;
			driver_powered_down <= 1'b1;
			driver_muted <= 1'b1;
			cm_loop_disable <= 1'b0;
			crosspoint_source_sel <= 1'b0;
		end else if (clk_en) begin
			sigdet_result <= next_sigdet;
			loss_of_signal <= next_los;
			sigdet_powerdown <= eq_ctrl[`RCR_EQ_SDPD];
			gain_select_high <= eq_ctrl[`RCR_EQ_GAIN];
			first_boost_bypass <= eq_ctrl[`RCR_EQ_BYPASS];
			equaliser_bias_sel <= {eq_ctrl[`RCR_EQ_BIAS_MSB],
				bias_ext[`RCR_BIAS_HI], bias_ext[`RCR_BIAS_LO]};
			sigdet_assert_threshold <= {sd_cfg[`RCR_SD_ATH_HI],
				sd_cfg[`RCR_SD_ATH_LO]};
			sigdet_deassert_threshold <= {sd_cfg[`RCR_SD_DTH_HI],
				sd_cfg[`RCR_SD_DTH_LO]};
			output_swing_sel <= {drv_ctrl[`RCR_DRV_SWING_HI],
				drv_ctrl[`RCR_DRV_SWING_LO]};
			// Manual power control, else follow loss of signal
			if (drv_ctrl[`RCR_DRIVER_POWERDOWN_OV]) begin
				driver_powered_down <= drv_ctrl[`RCR_DRIVER_POWERDOWN];
				equaliser_powered_down <= eq_ctrl[`RCR_EQ_PD];
			end else begin
				driver_powered_down <= next_los;
				equaliser_powered_down <= next_los;
			end
			// Manual mute bit is ignored without the override
			if (drv_ctrl[`RCR_DRV_MUTE_OV]) begin
				driver_muted <= drv_ctrl[`RCR_DRV_MUTE];
			end else begin
				driver_muted <= ~next_sigdet;
			end
			cm_loop_disable <= drv_ctrl[`RCR_DRV_CM];
			crosspoint_source_sel <= drv_ctrl[`RCR_DRV_SRC];
		end
	end

endmodule // rcr_channel_regs

`default_nettype wire

// ### dv/rcr_channel_regs_assertions.sv
// Checker for the redriver channel control register bank.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/1ns
`default_nettype none

module rcr_channel_regs_assertions (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic sigdet_result,
	input wire logic loss_of_signal,
	input wire logic sigdet_powerdown,
	input wire logic gain_select_high,
	input wire logic first_boost_bypass,
	input wire logic [2:0] equaliser_bias_sel,
	input wire logic [1:0] sigdet_assert_threshold,
	input wire logic [1:0] sigdet_deassert_threshold,
	input wire logic [1:0] output_swing_sel,
	input wire logic equaliser_powered_down,
	input wire logic driver_powered_down,
	input wire logic driver_muted,
	input wire logic cm_loop_disable,
	input wire logic crosspoint_source_sel
);
	// ************************************************************
	// Sequences and properties
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// Swing, threshold and bias outputs at their reset values
	sequence s_cfg_rst;
		output_swing_sel == 2'h3 && sigdet_deassert_threshold == 2'h1 &&
		sigdet_assert_threshold == 2'h0 && equaliser_bias_sel == 3'h0;
	endsequence
	// Bus clock held high long enough for any write to land
	sequence s_scl_hi8;
		scl_in [*8];
	endsequence

	property p_cfg_reset;
		$rose(reset_n) |-> s_cfg_rst;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset)
		else $error("config outputs off reset values");
	// Stays off until the detect synchroniser has flushed
	property p_pwr_reset;
		$rose(reset_n) |-> (driver_powered_down && equaliser_powered_down
			&& driver_muted && loss_of_signal) [*3];
	endproperty
	a_pwr_reset: assert property (p_pwr_reset)
		else $error("power or mute not asserted after reset");
	property p_bus_reset;
		$rose(reset_n) |-> !sda_oe [*4];
	endproperty
	a_bus_reset: assert property (p_bus_reset)
		else $error("data line pulled right after reset");
	property p_los;
		loss_of_signal == !sigdet_result;
	endproperty
	a_los: assert property (p_los)
		else $error("loss of signal not inverse of detect");
	property p_sda_out;
		sda_out == 1'b0;
	endproperty
	a_sda_out: assert property (p_sda_out)
		else $error("open drain output driven high");
	// Device changes the data line only while the bus clock is low
	property p_oe_rise;
		$rose(sda_oe) |-> !scl_in && !$past(scl_in);
	endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("data line pulled while clock high");
	property p_oe_fall;
		$fell(sda_oe) |-> !scl_in;
	endproperty
	a_oe_fall: assert property (p_oe_fall)
		else $error("data line released while clock high");
	property p_cfg_quiet;
		s_scl_hi8 |-> $stable({sigdet_powerdown, gain_select_high,
			first_boost_bypass, equaliser_bias_sel, sigdet_assert_threshold,
			sigdet_deassert_threshold, output_swing_sel, cm_loop_disable,
			crosspoint_source_sel});
	endproperty
	a_cfg_quiet: assert property (p_cfg_quiet)
		else $error("config output moved without bus write");
endmodule // rcr_channel_regs_assertions

bind rcr_channel_regs rcr_channel_regs_assertions u_chk (.clk(clk),
	.reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.sigdet_result(sigdet_result), .loss_of_signal(loss_of_signal),
	.sigdet_powerdown(sigdet_powerdown), .gain_select_high(gain_select_high),
	.first_boost_bypass(first_boost_bypass),
	.equaliser_bias_sel(equaliser_bias_sel),
	.sigdet_assert_threshold(sigdet_assert_threshold),
	.sigdet_deassert_threshold(sigdet_deassert_threshold),
	.output_swing_sel(output_swing_sel),
	.equaliser_powered_down(equaliser_powered_down),
	.driver_powered_down(driver_powered_down), .driver_muted(driver_muted),
	.cm_loop_disable(cm_loop_disable),
	.crosspoint_source_sel(crosspoint_source_sel));

`default_nettype wire

// ### dv/redriver_channel_control_regs_tb.sv
// Testbench for the redriver channel control register bank.
// Assumes default slave address; clk_en runs free except in one test.
`timescale 1ns/1ns
`default_nettype none

module redriver_channel_control_regs_tb;
	localparam logic [6:0] DA = 7'h18;
	logic clk, reset_n, scl_in, sda_m, sigdet_raw, a_t, clk_en;
	logic [7:0] q_t;
	wire sda_out, sda_oe, sigdet_result, loss_of_signal, sigdet_powerdown;
	wire gain_select_high, first_boost_bypass, equaliser_powered_down;
	wire driver_powered_down, driver_muted, cm_loop_disable;
	wire crosspoint_source_sel;
	wire [2:0] equaliser_bias_sel;
	wire [1:0] sigdet_assert_threshold, sigdet_deassert_threshold;
	wire [1:0] output_swing_sel;
	int miscompares, checks_done;
	// Open drain wire; packed output groups for compact compares
	wire sda_in = sda_m & (sda_oe ? sda_out : 1'b1);
	wire [7:0] eq_v = {sigdet_powerdown, gain_select_high, first_boost_bypass,
		equaliser_bias_sel, 2'h0};
	wire [7:0] pw_v = {sigdet_result, loss_of_signal, equaliser_powered_down,
		driver_powered_down, driver_muted, cm_loop_disable,
		crosspoint_source_sel, 1'b0};
	wire [7:0] th_v = {sigdet_assert_threshold, sigdet_deassert_threshold,
		output_swing_sel, 2'h0};

	rcr_channel_regs #(.DEV_ADDR(DA)) u_dut (.clk(clk), .reset_n(reset_n),
		.clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .sigdet_raw(sigdet_raw),
		.sigdet_result(sigdet_result), .loss_of_signal(loss_of_signal),
		.sigdet_powerdown(sigdet_powerdown),
		.gain_select_high(gain_select_high),
		.first_boost_bypass(first_boost_bypass),
		.equaliser_bias_sel(equaliser_bias_sel),
		.sigdet_assert_threshold(sigdet_assert_threshold),
		.sigdet_deassert_threshold(sigdet_deassert_threshold),
		.output_swing_sel(output_swing_sel),
		.equaliser_powered_down(equaliser_powered_down),
		.driver_powered_down(driver_powered_down),
		.driver_muted(driver_muted), .cm_loop_disable(cm_loop_disable),
		.crosspoint_source_sel(crosspoint_source_sel));

	// ************************************************************
	// Bus and compare tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Data moves 2 clocks after the clock falls, clear of its edge
	task start;
		sda_m = 1;
		wt(4);
		scl_in = 1;
		wt(6);
		sda_m = 0;
		wt(6);
		scl_in = 0;
		wt(2);
	endtask
	task stop;
		sda_m = 0;
		wt(4);
		scl_in = 1;
		wt(6);
		sda_m = 1;
		wt(6);
	endtask
	task automatic xfer(input logic [7:0] d, input logic mk,
		output logic [7:0] q, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_m = (i == 0) ? mk : d[(i > 0) ? i - 1 : 0];
			wt(4);
			scl_in = 1;
			wt(6);
			if (i > 0)
				q[i - 1] = sda_in;
			else
				ack = !sda_in;
			scl_in = 0;
			wt(2);
		end
	endtask
	task automatic sb(input logic [7:0] d, input logic e);
		xfer(d, 1'b1, q_t, a_t);
		chk("ack", {7'h0, e}, {7'h0, a_t});
	endtask
	task automatic wr(input logic [7:0] o, d0, d1, input int n);
		start;
		sb({DA, 1'b0}, 1'b1);
		sb(o, 1'b1);
		sb(d0, 1'b1);
		if (n > 1)
			sb(d1, 1'b1);
		stop;
	endtask
	task automatic rchk(input logic [7:0] o, e);
		start;
		sb({DA, 1'b0}, 1'b1);
		sb(o, 1'b1);
		start;
		sb({DA, 1'b1}, 1'b1);
		xfer(8'hff, 1'b1, q_t, a_t);
		stop;
		chk("register read", e, q_t);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_reset;
		chk("thresholds swing", 8'h1c, th_v);
		chk("power mute", 8'h78, pw_v);
		rchk(8'h04, 8'h90);
		rchk(8'h05, 8'h04);
		rchk(8'h06, 8'hc0);
		rchk(8'h07, 8'h00);
		rchk(8'h0f, 8'h00);
		rchk(8'h10, 8'h00);
		start;
		sb({7'h19, 1'b0}, 1'b0);
		stop;
		$display("t_reset done");
	endtask
	task t_eq;
		sigdet_raw = 1;
		wr(8'h04, 8'he3, 8'h00, 1);
		wr(8'h0f, 8'h20, 8'h00, 1);
		chk("eq outputs", 8'hf8, eq_v);
		chk("power mute", 8'h78, pw_v);
		rchk(8'h04, 8'he3);
		wr(8'h04, 8'h18, 8'h00, 1);
		chk("eq outputs", 8'h08, eq_v);
		chk("power mute", 8'h80, pw_v);
		$display("t_eq done");
	endtask
	task t_force;
		sigdet_raw = 1;
		wt(10);
		chk("power mute", 8'h80, pw_v);
		wr(8'h05, 8'h68, 8'h00, 1);
		chk("power mute", 8'h78, pw_v);
		chk("thresholds swing", 8'hac, th_v);
		sigdet_raw = 0;
		wr(8'h05, 8'h94, 8'h00, 1);
		wt(10);
		chk("power mute", 8'h80, pw_v);
		chk("thresholds swing", 8'h5c, th_v);
		$display("t_force done");
	endtask
	task t_drv;
		wr(8'h06, 8'h3e, 8'h5a, 2);
		chk("power mute", 8'hbc, pw_v);
		chk("thresholds swing", 8'h50, th_v);
		rchk(8'h07, 8'h5a);
		wr(8'h06, 8'h63, 8'h00, 1);
		chk("power mute", 8'ha2, pw_v);
		chk("thresholds swing", 8'h54, th_v);
		wr(8'h04, 8'h10, 8'h00, 1);
		chk("power mute", 8'h82, pw_v);
		$display("t_drv done");
	endtask
	// Mid-run reset with a live detect input, then a frozen enable
	task t_rst;
		sigdet_raw = 1;
		reset_n = 0;
		wt(8);
		reset_n = 1;
		wt(3);
		chk("eq outputs", 8'h00, eq_v);
		chk("thresholds swing", 8'h1c, th_v);
		rchk(8'h06, 8'hc0);
		rchk(8'h0f, 8'h00);
		chk("power mute", 8'h80, pw_v);
		clk_en = 0;
		sigdet_raw = 0;
		wt(10);
		chk("power mute", 8'h80, pw_v);
		clk_en = 1;
		wt(10);
		chk("power mute", 8'h78, pw_v);
		$display("t_rst done");
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Clock, main sequence and watchdog
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		reset_n = 0;
		scl_in = 1;
		sda_m = 1;
		sigdet_raw = 0;
		clk_en = 1;
		miscompares = 0;
		checks_done = 0;
		repeat (8) @(negedge clk);
		reset_n = 1;
		wt(3);
		t_reset;
		t_eq;
		t_force;
		t_drv;
		t_rst;
		report_and_stop;
	end
	// Run needs roughly 8k cycles; limit leaves wide margin
	initial begin
		#800000;
		miscompares++;
		report_and_stop;
	end
endmodule // redriver_channel_control_regs_tb

`default_nettype wire
